// file: hdl/nvmpc_pkg.sv
// Shared constants for the instruction prefetch cache
package nvmpc_pkg;
  // System clock rate in kHz
  localparam int CLK_KHZ = 125000;
  // Highest rate at which the program memory array may be accessed, in kHz
  localparam int ARR_MAX_KHZ = 8000;
  // Highest system clock at which cache hits still run without wait states, in kHz
  localparam int SYS_MAX_KHZ = 16000;
  // Clocks per array access; a least time, so it rounds up (1 at or below 8 MHz)
  localparam int ACC_CYC = (CLK_KHZ + ARR_MAX_KHZ - 1) / ARR_MAX_KHZ;
  // Cache shape
  localparam int WAYS = 2;
  localparam int LINE_WORDS = 4;
  localparam int WORD_BITS = 16;
  localparam int LINE_BITS = 64;
  localparam int OFS_BITS = 2;
  localparam int LINE_BYTES = 8;
  // Instruction words that both resident lines hold together
  localparam int LOOP_WORDS = 8;
  // Word offset of the last word in a line
  localparam logic [1:0] LAST_OFS = 2'h3;
  // Default word address width
  localparam int ADDR_BITS = 15;
  // Sequencer states, Gray along idle -> busy
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_BUSY = 2'h1} nvmpc_state_t;
  // Kinds of array access
  typedef enum logic [1:0] {
    OP_FETCH = 2'h0,
    OP_PREF = 2'h1,
    OP_DRD = 2'h3,
    OP_DWR = 2'h2
  } nvmpc_op_t;
endpackage : nvmpc_pkg

// file: hdl/nvmpc_pacer.sv
`timescale 1ns/1ps
// Counts the clocks of one array access and flags its last clock
module nvmpc_pacer #(
  parameter int ACC = nvmpc_pkg::ACC_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Access in progress, held for the whole access
  input wire logic run,
  // Last clock of the access
  output logic done
);
  localparam int CW = (ACC < 2) ? 1 : $clog2(ACC);

  logic [CW-1:0] cnt_ff; // Clocks elapsed in this access
  logic [CW-1:0] nxt_cnt;

  // Wait states come from holding run; done ends the access after ACC clocks
  always_comb begin
    done = run && (cnt_ff == CW'(ACC - 1));
    if (!run || done) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : nvmpc_pacer

// file: hdl/nvmpc_cache.sv
`timescale 1ns/1ps
// Functional notes
// - Two ways, 64-bit lines of four words
// - Fetch aligned four-word group around program counter
// - Last word reached: prefetch next group, other way
// - Absent jump target refills from new location
// - Resident line served without array access
// - Only array accesses throttled; hits at full clock
// - Data accesses bypass cache; writes invalidate hits
// - Wait states only above 8 MHz
// - Access length is clock over 8 MHz
// - Long loops refill on each non-resident line
// - Four-word blocks; writes time as reads
// - Read rewrite is inside the array access
// - Direct writes, no erase of any kind
module nvmpc_cache #(
  parameter int AW = nvmpc_pkg::ADDR_BITS,
  parameter int ACC = nvmpc_pkg::ACC_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Instruction fetch port (word address)
  input wire logic if_req,
  input wire logic [AW-1:0] if_addr,
  output logic if_gnt,
  output logic if_valid,
  output logic [nvmpc_pkg::WORD_BITS-1:0] if_data,
  // Data port (word address, byte enables)
  input wire logic d_req,
  input wire logic d_we,
  input wire logic [AW-1:0] d_addr,
  input wire logic [1:0] d_be,
  input wire logic [nvmpc_pkg::WORD_BITS-1:0] d_wdata,
  output logic d_gnt,
  output logic d_done,
  output logic [nvmpc_pkg::WORD_BITS-1:0] d_rdata,
  // Program memory array port (block address)
  output logic arr_en,
  output logic arr_we,
  output logic [AW-nvmpc_pkg::OFS_BITS-1:0] arr_addr,
  output logic [nvmpc_pkg::LINE_BITS-1:0] arr_wdata,
  output logic [nvmpc_pkg::LINE_BYTES-1:0] arr_wmask,
  input wire logic [nvmpc_pkg::LINE_BITS-1:0] arr_rdata
);
  localparam int BW = AW - nvmpc_pkg::OFS_BITS;
  localparam int NW = nvmpc_pkg::WAYS;
  localparam int LB = nvmpc_pkg::LINE_BITS;
  localparam int WB = nvmpc_pkg::WORD_BITS;

  nvmpc_pkg::nvmpc_state_t state_ff, nxt_state; // Sequencer state
  nvmpc_pkg::nvmpc_op_t op_ff, nxt_op; // Access in flight
  logic [BW-1:0] cur_blk_ff, nxt_cur_blk; // Block under access
  logic fill_way_ff, nxt_fill_way; // Way a fill lands in
  logic [LB-1:0] wdat_ff, nxt_wdat; // Write data, replicated per word
  logic [nvmpc_pkg::LINE_BYTES-1:0] mask_ff, nxt_mask; // Write byte mask
  logic [1:0] wofs_ff, nxt_wofs; // Word offset of a data access
  logic [NW-1:0] valid_ff, nxt_valid; // Line valid bits
  logic [BW-1:0] tag_ff [NW]; // Block address held by each way
  logic [BW-1:0] nxt_tag [NW];
  logic [LB-1:0] line_ff [NW]; // Cached instruction words
  logic [LB-1:0] nxt_line [NW];
  logic lru_ff, nxt_lru; // Way that last served a fetch
  logic pf_pend_ff, nxt_pf_pend; // Sequential prefetch waiting
  logic [BW-1:0] pf_blk_ff, nxt_pf_blk; // Block to prefetch
  logic if_valid_ff, nxt_if_valid; // Fetch answer strobe
  logic [WB-1:0] if_data_ff, nxt_if_data;
  logic d_done_ff, nxt_d_done; // Data answer strobe
  logic [WB-1:0] d_rdata_ff, nxt_d_rdata;

  logic [BW-1:0] fblk; // Block of the fetch address
  logic [1:0] fofs; // Word within that block
  logic [BW-1:0] dblk; // Block of the data address
  logic [NW-1:0] hit_w; // Fetch address resident per way
  logic [NW-1:0] nres_w; // Following block resident per way
  logic [NW-1:0] pres_w; // Pending prefetch block resident per way
  logic [NW-1:0] dhit_w; // Data address resident per way
  logic hit;
  logic hit_way;
  logic vic; // Fill victim
  logic acc_done; // Last clock of an array access

  assign fblk = if_addr[AW-1:nvmpc_pkg::OFS_BITS];
  assign fofs = if_addr[nvmpc_pkg::OFS_BITS-1:0];
  assign dblk = d_addr[AW-1:nvmpc_pkg::OFS_BITS];

  // Tag compare per way; one set, two ways, eight words in all
  for (genvar w = 0; w < NW; w++) begin : g_way
    assign hit_w[w] = valid_ff[w] && (tag_ff[w] == fblk);
    assign nres_w[w] = valid_ff[w] && (tag_ff[w] == fblk + 1'b1);
    assign pres_w[w] = valid_ff[w] && (tag_ff[w] == pf_blk_ff);
    assign dhit_w[w] = valid_ff[w] && (tag_ff[w] == dblk);
  end
  assign hit = |hit_w;
  assign hit_way = hit_w[1];

  // Access length; wait states only appear when the clock is above 8 MHz
  nvmpc_pacer #(.ACC(ACC)) i_nvmpc_pacer (
    .mclk(mclk),
    .rstn(rstn),
    .run(state_ff == nvmpc_pkg::ST_BUSY),
    .done(acc_done)
  );

  // Array port straight from the access registers
  assign arr_en = (state_ff == nvmpc_pkg::ST_BUSY);
  assign arr_we = arr_en && (op_ff == nvmpc_pkg::OP_DWR);
  assign arr_addr = cur_blk_ff;
  assign arr_wdata = wdat_ff;
  assign arr_wmask = mask_ff;
  assign if_valid = if_valid_ff;
  assign if_data = if_data_ff;
  assign d_done = d_done_ff;
  assign d_rdata = d_rdata_ff;

  // Sequencer, lookup and fill
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_cur_blk = cur_blk_ff;
    nxt_fill_way = fill_way_ff;
    nxt_wdat = wdat_ff;
    nxt_mask = mask_ff;
    nxt_wofs = wofs_ff;
    nxt_valid = valid_ff;
    nxt_tag = tag_ff;
    nxt_line = line_ff;
    nxt_lru = lru_ff;
    nxt_pf_pend = pf_pend_ff;
    nxt_pf_blk = pf_blk_ff;
    nxt_d_done = 1'b0;
    nxt_d_rdata = d_rdata_ff;
    nxt_if_data = if_data_ff;
    // Invalid way first, otherwise keep the way now executing
    if (!valid_ff[0]) begin
      vic = 1'b0;
    end else if (!valid_ff[1]) begin
      vic = 1'b1;
    end else begin
      vic = ~lru_ff;
    end
    // Hits are served even while the array is busy, so they never wait
    if_gnt = if_req && hit;
    nxt_if_valid = if_gnt;
    d_gnt = d_req && (state_ff == nvmpc_pkg::ST_IDLE);
    if (if_gnt) begin
      nxt_if_data = line_ff[hit_way][{fofs, 4'h0} +: WB];
      nxt_lru = hit_way;
    end
    case (state_ff)
      nvmpc_pkg::ST_IDLE: begin
        if (d_req) begin
          // Data goes to the array; no allocation, a write invalidates a resident copy
          nxt_op = d_we ? nvmpc_pkg::OP_DWR : nvmpc_pkg::OP_DRD;
          nxt_cur_blk = dblk;
          nxt_wofs = d_addr[1:0];
          nxt_wdat = {4{d_wdata}};
          nxt_mask = {6'h00, d_be} << {d_addr[1:0], 1'b0};
          nxt_state = nvmpc_pkg::ST_BUSY;
          if (d_we) begin
            nxt_valid = valid_ff & ~dhit_w;
          end
        end else if (if_req && !hit) begin
          // Demand miss, also a jump to an absent target
          nxt_op = nvmpc_pkg::OP_FETCH;
          nxt_cur_blk = fblk;
          nxt_fill_way = vic;
          nxt_valid[vic] = 1'b0;
          nxt_state = nvmpc_pkg::ST_BUSY;
        end else if (pf_pend_ff) begin
          nxt_pf_pend = 1'b0;
          if (!(|pres_w)) begin
            nxt_op = nvmpc_pkg::OP_PREF;
            nxt_cur_blk = pf_blk_ff;
            nxt_fill_way = vic;
            nxt_valid[vic] = 1'b0;
            nxt_state = nvmpc_pkg::ST_BUSY;
          end
        end
      end
      nvmpc_pkg::ST_BUSY: begin
        if (acc_done) begin
          // The array rewrites what it reads within this same access
          nxt_state = nvmpc_pkg::ST_IDLE;
          case (op_ff)
            nvmpc_pkg::OP_FETCH, nvmpc_pkg::OP_PREF: begin
              nxt_line[fill_way_ff] = arr_rdata;
              nxt_tag[fill_way_ff] = cur_blk_ff;
              nxt_valid[fill_way_ff] = 1'b1;
            end
            nvmpc_pkg::OP_DRD: begin
              nxt_d_done = 1'b1;
              nxt_d_rdata = arr_rdata[{wofs_ff, 4'h0} +: WB];
            end
            default: begin
              // A write takes exactly as long as a read
              nxt_d_done = 1'b1;
            end
          endcase
        end
      end
      default: begin
        nxt_state = nvmpc_pkg::ST_IDLE;
      end
    endcase
    // Last word fetched: queue the next group; a new trigger beats the clear
    if (if_gnt && (fofs == nvmpc_pkg::LAST_OFS) && !(|nres_w)) begin
      nxt_pf_pend = 1'b1;
      nxt_pf_blk = fblk + 1'b1;
    end
  end

  // State registers; reset empties the cache
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= nvmpc_pkg::ST_IDLE;
      op_ff <= nvmpc_pkg::OP_FETCH;
      cur_blk_ff <= '0;
      fill_way_ff <= 1'b0;
      wdat_ff <= '0;
      mask_ff <= '0;
      wofs_ff <= 2'h0;
      valid_ff <= '0;
      for (int w = 0; w < NW; w++) begin
        tag_ff[w] <= '0;
        line_ff[w] <= '0;
      end
      lru_ff <= 1'b0;
      pf_pend_ff <= 1'b0;
      pf_blk_ff <= '0;
      if_valid_ff <= 1'b0;
      if_data_ff <= '0;
      d_done_ff <= 1'b0;
      d_rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      cur_blk_ff <= nxt_cur_blk;
      fill_way_ff <= nxt_fill_way;
      wdat_ff <= nxt_wdat;
      mask_ff <= nxt_mask;
      wofs_ff <= nxt_wofs;
      valid_ff <= nxt_valid;
      tag_ff <= nxt_tag;
      line_ff <= nxt_line;
      lru_ff <= nxt_lru;
      pf_pend_ff <= nxt_pf_pend;
      pf_blk_ff <= nxt_pf_blk;
      if_valid_ff <= nxt_if_valid;
      if_data_ff <= nxt_if_data;
      d_done_ff <= nxt_d_done;
      d_rdata_ff <= nxt_d_rdata;
    end
  end

  // Helper: clocks of the current array access, counted independently
  logic [15:0] len_ff;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      len_ff <= 16'h0000;
    end else begin
      len_ff <= (arr_en && !acc_done) ? len_ff + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_reset_empty: assert property (@(posedge mclk) disable iff (1'b0)
    !rstn |=> valid_ff == '0) else $error("cache not empty after reset");
  a_grant_hit: assert property (if_gnt |-> hit ##1 (if_valid &&
    if_data == $past(line_ff[hit_way][{fofs, 4'h0} +: WB]))) else $error("bad hit answer");
  a_miss_fill: assert property ((state_ff == nvmpc_pkg::ST_IDLE) && !d_req &&
    if_req && !hit |=> arr_en && !arr_we && arr_addr == $past(fblk))
    else $error("miss did not start fill");
  a_acc_len: assert property (acc_done |-> len_ff == 16'(ACC - 1))
    else $error("array access length wrong");
  a_acc_end: assert property (acc_done |=> !arr_en ##1 1'b1)
    else $error("access did not end");
  a_data_bypass: assert property (d_gnt |=> arr_en ##[0:300] d_done)
    else $error("data access not sent to array");
  a_wr_inval: assert property (d_gnt && d_we |=> (valid_ff & $past(dhit_w)) == '0)
    else $error("stale line after write");
  a_pf_keep: assert property (arr_en && op_ff == nvmpc_pkg::OP_PREF &&
    valid_ff[lru_ff] |-> fill_way_ff != lru_ff) else $error("prefetch evicts live line");
  // The block address moves on the first clock of a write, so only later clocks hold it
  a_write_only: assert property (arr_we |-> op_ff == nvmpc_pkg::OP_DWR &&
    (!$past(arr_en) || $stable(arr_addr))) else $error("unexpected array write");

  c_hit: cover property (if_gnt ##1 if_gnt);
  c_miss: cover property (if_req && !hit ##[1:300] if_gnt);
  c_pref: cover property (arr_en && op_ff == nvmpc_pkg::OP_PREF);
  c_wr_inval: cover property (d_gnt && d_we && (|dhit_w));
endmodule : nvmpc_cache

// file: verification/nvmpc_array_model.sv
`timescale 1ns/1ps
// Behavioural program memory array behind the cache, four-word blocks
module nvmpc_array_model #(
  parameter int ACC = 2
) (
  // Clock
  input wire logic mclk,
  // Array port from the cache
  input wire logic arr_en,
  input wire logic arr_we,
  input wire logic [12:0] arr_addr,
  input wire logic [63:0] arr_wdata,
  input wire logic [7:0] arr_wmask,
  output logic [63:0] arr_rdata,
  // Bookkeeping seen by the bench
  output int n_acc,
  output int bad_len
);
  logic [63:0] mem [8192]; // Block store, word w preloaded as {1, w}
  logic [63:0] last_q; // Last block shown, inverted once released
  int run_cnt; // Clocks of the current access so far

  // Preload a pattern the bench can predict from the address alone
  initial begin
    n_acc = 0;
    bad_len = 0;
    run_cnt = 0;
    last_q = 64'h0;
    for (int b = 0; b < 8192; b++) begin
      for (int i = 0; i < 4; i++) begin
        mem[b][16*i +: 16] = {1'b1, b[12:0], i[1:0]};
      end
    end
  end

  // Released bus shows the inverse, so a stale sample never matches
  assign arr_rdata = arr_en ? mem[arr_addr] : ~last_q;

  // Close an access on its last clock; reads and writes take the same length
  always @(posedge mclk) begin
    if (arr_en) begin
      last_q <= mem[arr_addr];
      run_cnt <= run_cnt + 1;
      if (run_cnt + 1 > ACC) begin
        bad_len <= bad_len + 1;
      end
      if (run_cnt + 1 == ACC) begin
        n_acc <= n_acc + 1;
        // Direct byte write, no erase step; a read rewrites in place
        for (int k = 0; k < 8; k++) begin
          if (arr_we && arr_wmask[k]) begin
            mem[arr_addr][8*k +: 8] <= arr_wdata[8*k +: 8];
          end
        end
      end
    end else begin
      if (run_cnt != 0 && run_cnt != ACC) begin
        bad_len <= bad_len + 1;
      end
      run_cnt <= 0;
    end
  end
endmodule : nvmpc_array_model

// file: verification/nvmpc_cache_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the prefetch cache
module nvmpc_cache_tb_top;
  localparam int ACC = 2; // Two clocks per access, as at twice the array rate
  localparam int M = 1 + ACC; // Clocks a fetch miss waits for its grant
  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
  logic mclk, rstn, if_req, if_gnt, if_valid, d_req, d_we, d_gnt, d_done, arr_en, arr_we;
  logic [14:0] if_addr, d_addr;
  logic [15:0] if_data, d_wdata, d_rdata, rd;
  logic [1:0] d_be;
  logic [12:0] arr_addr;
  logic [63:0] arr_wdata, arr_rdata;
  logic [7:0] arr_wmask;
  int err_count, compares, cyc, n_acc, bad_len, n, a0;
  // Ordinary fetch rows: address, grant wait, array accesses, idle clocks after
  logic [14:0] r_addr [9] = '{15'h0010, 15'h0011, 15'h0012, 15'h0013, 15'h0014,
    15'h0011, 15'h0100, 15'h0011, 15'h0014};
  int r_wait [9] = '{M, 0, 0, 0, 0, 0, M, 0, M};
  int r_acc [9] = '{1, 0, 0, 1, 0, 0, 1, 0, 1};
  int r_gap [9] = '{0, 0, 0, 6, 0, 0, 0, 0, 0};

  nvmpc_cache #(.ACC(ACC)) i_nvmpc_cache (.mclk(mclk), .rstn(rstn), .if_req(if_req),
    .if_addr(if_addr), .if_gnt(if_gnt), .if_valid(if_valid), .if_data(if_data),
    .d_req(d_req), .d_we(d_we), .d_addr(d_addr), .d_be(d_be), .d_wdata(d_wdata),
    .d_gnt(d_gnt), .d_done(d_done), .d_rdata(d_rdata), .arr_en(arr_en), .arr_we(arr_we),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wmask(arr_wmask),
    .arr_rdata(arr_rdata));
  nvmpc_array_model #(.ACC(ACC)) i_nvmpc_array_model (.mclk(mclk), .arr_en(arr_en),
    .arr_we(arr_we), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wmask(arr_wmask),
    .arr_rdata(arr_rdata), .n_acc(n_acc), .bad_len(bad_len));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Hang guard, far above the few dozen clocks the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // Counts, verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Reset held low for a number of clocks, released at a falling edge
  task automatic do_reset(input int clocks);
    rstn = 1'b0;
    repeat (clocks) @(negedge mclk);
    rstn = 1'b1;
  endtask : do_reset

  // One instruction fetch; n returns the clocks spent waiting for the grant
  task automatic fetch(input logic [14:0] a);
    n = 0;
    if_req = 1'b1;
    if_addr = a;
    #1;
    while (if_gnt !== 1'b1 && n < 100) begin
      @(negedge mclk);
      #1;
      n++;
    end
    // Request stays up, so a following fetch runs back to back with no gap
    @(negedge mclk);
    `CHK(if_valid, 1'b1)
    `CHK(if_data, {1'b1, a})
  endtask : fetch

  // One data access; checks its length and returns the read word in rd
  task automatic data(input logic we, input logic [14:0] a, input logic [1:0] be,
      input logic [15:0] wd);
    n = 0;
    d_req = 1'b1;
    d_we = we;
    d_addr = a;
    d_be = be;
    d_wdata = wd;
    #1;
    while (d_gnt !== 1'b1 && n < 100) begin
      @(negedge mclk);
      #1;
      n++;
    end
    // Drop the request once, after the taking edge, then count to the answer
    @(negedge mclk);
    d_req = 1'b0;
    n = 1;
    while (d_done !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n, ACC + 1)
    rd = d_rdata;
  endtask : data

  // Main sequence
  initial begin
    err_count = 0;
    compares = 0;
    cyc = 0;
    rstn = 1'b0;
    if_req = 1'b0;
    if_addr = 15'h0000;
    d_req = 1'b0;
    d_we = 1'b0;
    d_addr = 15'h0000;
    d_be = 2'h0;
    d_wdata = 16'h0000;
    @(negedge mclk);
    do_reset(16);
    // Ordinary fetch rows: misses, hits, prefetch into the other way, eviction
    for (int i = 0; i < 9; i++) begin
      a0 = n_acc;
      fetch(r_addr[i]);
      `CHK(n, r_wait[i])
      // Idle rows let the queued prefetch run with the fetch port quiet
      if (r_gap[i] > 0) begin
        if_req = 1'b0;
      end
      repeat (r_gap[i]) @(negedge mclk);
      `CHK(n_acc - a0, r_acc[i])
    end
    if_req = 1'b0;
    // Low byte write into a resident line, then the line must be refetched
    data(1'b1, 15'h0011, 2'h1, 16'h5A5A);
    a0 = n_acc;
    n = 0;
    if_req = 1'b1;
    if_addr = 15'h0011;
    #1;
    while (if_gnt !== 1'b1 && n < 100) begin
      @(negedge mclk);
      #1;
      n++;
    end
    @(negedge mclk);
    if_req = 1'b0;
    `CHK(if_data, 16'h805A)
    `CHK(n, M)
    `CHK(n_acc - a0, 1)
    // Back-to-back data reads of an uncached and a resident word, no allocation follows
    data(1'b0, 15'h0200, 2'h3, 16'h0000);
    `CHK(rd, 16'h8200)
    data(1'b0, 15'h0011, 2'h3, 16'h0000);
    `CHK(rd, 16'h805A)
    fetch(15'h0200);
    `CHK(n, M)
    if_req = 1'b0;
    // Second reset mid-run drops every line
    do_reset(2);
    fetch(15'h0200);
    `CHK(n, M)
    `CHK(bad_len, 0)
    report_and_stop();
  end
endmodule : nvmpc_cache_tb_top
